/* logic/scr_clkdiv.sv */
/*
 * scr_clkdiv: divided clock output; toggles every ratio+1 enabled cycles.
 * assumes: clk_i is the reference master clock timebase, ratio is static
 * while enabled (a change applies at once to the count in progress).
 */
`timescale 1ns/1ns
module scr_clkdiv #(
	parameter int W = 2
) (
	input  wire logic         clk_i,
	input  wire logic         sys_rst_i,
	input  wire logic         ce_i,
	input  wire logic         clear_i,
	input  wire logic         enable_i,
	input  wire logic [W-1:0] ratio_i,
	output logic              clk_out_o
);
	typedef struct packed {
		logic [W-1:0] cnt;
		logic         out;
	} scr_div_t;
	scr_div_t st;
	scr_div_t next_st;

	initial begin
		if (W < 1 || W > 8) $error("scr_clkdiv: W out of range");
	end

	always_comb begin
		next_st = st;
		if (clear_i || !enable_i) begin
			next_st = '0;
		end else if (st.cnt >= ratio_i) begin
			next_st.cnt = '0;
			next_st.out = ~st.out;
		end else begin
			next_st.cnt = st.cnt + W'(1);
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			st <= '0;
		end else if (ce_i) begin
			st <= next_st;
		end
	end

	assign clk_out_o = st.out;
endmodule

/* logic/scr_device.sv */
/*
 * scr_device: synthesizer control and status registers, event latch and
 * interrupt request, calibration handshake and clock output divider.
 * assumes: analog side gives one-cycle event pulses on clk_i; the host
 * keeps to the link timing of scr_link_if.
 */
// The plain strobed port was decided locally.
`timescale 1ns/1ns

// Notes on behaviour
// - clock output divides by field plus one
// - host sets divider before enabling clock output
// - master clock enable gates all synthesizer functions; here it gates loop enable, calibration, events and clock output only
// - register access works without master clock
// - calibration needs trigger and loop enable
// - trigger readback clears when calibration completes
// - external vco calibrates charge pump only
// - bit 2 selects external vco polarity
// - bit 1 selects internal or external vco
// - loop enable powers internal vco unless external
// - source enable bit; frequency 10 to 120
// - host pauses master clock around frequency change
// - reset command restores all register defaults
// - events latch only when enabled
// - latched event clears its enable bit
// - interrupt low when status and mask set
// - common event layout; enable, mask reset 40
// - status read returns and clears it
// - host double-checks lock-lost and recalibration events
// - source divider 4 to 127, reset 08
// - readbacks mirror their write registers
// - host writes zero to loop bit 5
// - mode 0 integer, 2 fractional
// - width bit chooses 24 or 16 bit fraction
module scr_device (
	input  wire logic       clk_i,
	input  wire logic       sys_rst_i,
	input  wire logic       ce_i,
	scr_link_if.dev         link,
	input  wire logic       mclk_ready_i,
	input  wire logic       cal_done_i,
	input  wire logic       lock_lost_i,
	input  wire logic       lock_gained_i,
	input  wire logic       recal_needed_i,
	input  wire logic [7:0] vco_status_i,
	output logic            clock_out_o,
	output logic            synth_master_clock_enable_o,
	output logic            loop_enable_o,
	output logic            internal_vco_power_o,
	output logic            external_vco_select_o,
	output logic            external_vco_polarity_o,
	output logic            cal_start_o,
	output logic            cal_with_vco_o,
	output logic            cal_busy_o,
	output logic            source_divider_enable_o,
	output logic [6:0]      synth_clock_freq_o,
	output logic [6:0]      source_divide_value_o,
	output logic            integer_mode_o,
	output logic            fractional_mode_o,
	output logic            fraction_24bit_o,
	output logic [7:0]      output_enables_o
);
	import scr_pkg::*;
	typedef enum logic [0:0] {
		CAL_IDLE = 1'b0,
		CAL_RUN  = 1'b1
	} scr_cal_t;

	typedef struct packed {
		logic [15:0] gcr;
		logic [7:0]  freq;
		logic [7:0]  ev_en;
		logic [7:0]  ev_mask;
		logic [7:0]  ev_stat;
		logic [7:0]  loop_ctl;
		logic [6:0]  source_divide_value;
		logic [1:0]  ckdiv;
		scr_cal_t    cal;
		logic        cal_start;
		logic [15:0] rdata;
		logic        irq_n;
		logic        soft_rst;
	} scr_dev_t;

	localparam scr_dev_t DEV_RESET = '{
		gcr: RST_GCR, freq: RST_FREQ, ev_en: RST_EV, ev_mask: RST_EV,
		ev_stat: 8'h00, loop_ctl: RST_LOOP, source_divide_value: RST_SOURCE_DIVIDE_VALUE, ckdiv: RST_CKDIV,
		cal: CAL_IDLE, cal_start: 1'b0, rdata: 16'h0000, irq_n: 1'b1,
		soft_rst: 1'b0
	};

	scr_dev_t st;
	scr_dev_t next_st;
	logic [7:0] raw_ev;
	logic [7:0] new_ev;
	logic       mclk_on;

	always_comb begin
		next_st = st;
		next_st.cal_start = 1'b0;
		next_st.soft_rst = 1'b0;
		mclk_on = st.gcr[GCR_MCLK_EN];
		raw_ev = 8'h00;
		// analog events only count while the master clock runs
		if (mclk_on) begin
			raw_ev[EV_MCLK_READY] = mclk_ready_i;
			raw_ev[EV_CAL_DONE]   = cal_done_i && st.cal == CAL_RUN;
			raw_ev[EV_LOCK_LOST]  = lock_lost_i;
			raw_ev[EV_LOCK_GAIN]  = lock_gained_i;
			raw_ev[EV_RECAL]      = recal_needed_i;
		end
		new_ev = raw_ev & st.ev_en & EV_USED;

		// register writes are served whatever the master clock does
		if (link.wr) begin
			unique case (link.addr)
				OFS_GCR:     next_st.gcr = link.wdata & GCR_USED;
				OFS_FREQ:    next_st.freq = link.wdata[7:0];
				OFS_EV_EN:   next_st.ev_en = link.wdata[7:0] & EV_USED;
				OFS_EV_MASK: next_st.ev_mask = link.wdata[7:0] & EV_USED;
				OFS_LOOP:    next_st.loop_ctl = link.wdata[7:0] & LOOP_USED;
				OFS_SOURCE_DIVIDE_VALUE:    next_st.source_divide_value = link.wdata[6:0];
				OFS_CKDIV:   next_st.ckdiv = link.wdata[1:0];
				default:     next_st = next_st;
			endcase
		end

		// calibration: trigger with loop enable, master clock running
		unique case (st.cal)
			CAL_IDLE: begin
				if (mclk_on && st.gcr[GCR_CAL] && st.gcr[GCR_LOOP_EN]) begin
					next_st.cal = CAL_RUN;
					next_st.cal_start = 1'b1;
				end
			end
			CAL_RUN: begin
				if (cal_done_i && mclk_on) begin
					next_st.cal = CAL_IDLE;
					next_st.gcr[GCR_CAL] = 1'b0;
				end
			end
		endcase

		// read data one cycle after the strobe; status clears on read
		next_st.rdata = 16'h0000;
		if (link.rd) begin
			unique case (link.addr)
				OFS_SOURCE_DIVIDE_VALUE_RB:   next_st.rdata = {9'h000, st.source_divide_value};
				OFS_GCR_RB:    next_st.rdata = st.gcr;
				OFS_FREQ_RB:   next_st.rdata = {8'h00, st.freq};
				OFS_EV_STAT:   next_st.rdata = {8'h00, st.ev_stat};
				OFS_EV_EN_RB:  next_st.rdata = {8'h00, st.ev_en};
				OFS_EV_MSK_RB: next_st.rdata = {8'h00, st.ev_mask};
				OFS_VCO_STAT:  next_st.rdata = {8'h00, vco_status_i & VCO_USED};
				OFS_REFDIV_RB: next_st.rdata = {8'h00, RST_REFDIV};
				OFS_REFPWR_RB: next_st.rdata = {8'h00, RST_REFPWR};
				OFS_CKDIV_RB:  next_st.rdata = {14'h0000, st.ckdiv};
				default:       next_st.rdata = 16'h0000;
			endcase
		end
		// a new event in the reading cycle survives the clear
		if (link.rd && link.addr == OFS_EV_STAT) begin
			next_st.ev_stat = new_ev;
		end else begin
			next_st.ev_stat = st.ev_stat | new_ev;
		end
		// a latched event disarms itself, even against a same-cycle write
		next_st.ev_en = next_st.ev_en & ~new_ev;

		// general reset command wins over everything else
		if (link.wr && link.addr == OFS_GEN_RST) begin
			next_st = DEV_RESET;
			next_st.soft_rst = 1'b1;
		end
		next_st.irq_n = ~|(next_st.ev_stat & next_st.ev_mask);
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			st <= DEV_RESET;
		end else if (ce_i) begin
			st <= next_st;
		end
	end

	// divider only runs with the master clock enabled
	scr_clkdiv #(
		.W(2)
	) u_clkdiv (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.ce_i      (ce_i),
		.clear_i   (st.soft_rst),
		.enable_i  (link.clock_out_enable && st.gcr[GCR_MCLK_EN]),
		.ratio_i   (st.ckdiv),
		.clk_out_o (clock_out_o)
	);

	assign link.rdata = st.rdata;
	assign link.interrupt_request_n = st.irq_n;
	assign synth_master_clock_enable_o = st.gcr[GCR_MCLK_EN];
	assign loop_enable_o = st.gcr[GCR_LOOP_EN] && st.gcr[GCR_MCLK_EN];
	assign internal_vco_power_o = loop_enable_o && !st.gcr[GCR_EXT_VCO];
	assign external_vco_select_o = st.gcr[GCR_EXT_VCO];
	assign external_vco_polarity_o = st.gcr[GCR_EXT_POL];
	assign cal_start_o = st.cal_start;
	assign cal_with_vco_o = !st.gcr[GCR_EXT_VCO];
	assign cal_busy_o = st.cal == CAL_RUN;
	assign source_divider_enable_o = st.freq[FREQ_SRC_EN];
	assign synth_clock_freq_o = st.freq[6:0];
	assign source_divide_value_o = st.source_divide_value;
	assign integer_mode_o = st.loop_ctl[2:0] == MODE_INTEGER;
	assign fractional_mode_o = st.loop_ctl[2:0] == MODE_FRACT;
	assign fraction_24bit_o = !st.loop_ctl[LOOP_WIDTH_SEL];
	assign output_enables_o = {st.gcr[GCR_OUT2], st.gcr[GCR_OUT1], st.gcr[GCR_LOCK_DET],
		5'h00};
endmodule

/* logic/scr_host.sv */
/*
 * scr_host: host controller; software orders link accesses through a
 * small register port, the controller screens them and runs the link.
 * assumes: device answers a link read one cycle after its strobe.
 */
`timescale 1ns/1ns

module scr_host (
	input  wire logic        clk_i,
	input  wire logic        sys_rst_i,
	input  wire logic        ce_i,
	scr_link_if.host         link,
	input  wire logic [2:0]  reg_addr_i,
	input  wire logic [15:0] reg_wdata_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	output logic [15:0]      reg_rdata_o,
	output logic             irq_o
);
	import scr_pkg::*;
	typedef enum logic [1:0] {
		H_IDLE  = 2'b00,
		H_ISSUE = 2'b01,
		H_WAIT  = 2'b10,
		H_CAPT  = 2'b11
	} scr_hst_t;

	typedef struct packed {
		scr_hst_t    fsm;
		logic [7:0]  addr;
		logic [15:0] wdata;
		logic        is_read;
		logic [15:0] rdata;
		logic        refused;
		logic        suspect;
		logic        ckdiv_set;
		logic        ckout_req;
		logic        gcr_mclk;
		logic        l_wr;
		logic        l_rd;
		logic [15:0] reg_rdata;
		logic        irq;
		logic        irq_s1;
	} scr_host_t;

	scr_host_t st;
	scr_host_t next_st;
	logic [15:0] out_data;
	logic        bad;

	always_comb begin
		next_st = st;
		next_st.l_wr = 1'b0;
		next_st.l_rd = 1'b0;
		bad = 1'b0;
		out_data = st.wdata;
		// screen the order before it reaches the link
		if (st.addr == OFS_LOOP) begin
			out_data[LOOP_RSVD] = 1'b0;
		end
		if (st.addr == OFS_GCR && st.wdata[GCR_CAL]) begin
			out_data[GCR_LOOP_EN] = 1'b1;
		end
		if (st.addr == OFS_FREQ) begin
			bad = st.wdata[6:0] < FREQ_MIN || st.wdata[6:0] > FREQ_MAX
				|| st.gcr_mclk;
		end
		if (st.addr == OFS_SOURCE_DIVIDE_VALUE) begin
			bad = st.wdata[6:0] < SOURCE_DIVIDE_VALUE_MIN;
		end

		unique case (st.fsm)
			H_IDLE: begin
				if (reg_wr_i && reg_addr_i == HOF_GO
					&& (reg_wdata_i[GO_WRITE] || reg_wdata_i[GO_READ])) begin
					next_st.fsm = H_ISSUE;
					next_st.is_read = reg_wdata_i[GO_READ];
				end
			end
			H_ISSUE: begin
				if (st.is_read) begin
					next_st.l_rd = 1'b1;
					next_st.fsm = H_WAIT;
				end else if (bad) begin
					next_st.refused = 1'b1;
					next_st.fsm = H_IDLE;
				end else begin
					next_st.l_wr = 1'b1;
					next_st.wdata = out_data;
					next_st.fsm = H_IDLE;
					if (st.addr == OFS_CKDIV) next_st.ckdiv_set = 1'b1;
					if (st.addr == OFS_GCR) next_st.gcr_mclk = out_data[GCR_MCLK_EN];
					if (st.addr == OFS_GEN_RST) begin
						next_st.gcr_mclk = 1'b0;
						next_st.ckdiv_set = 1'b0;
					end
				end
			end
			H_WAIT: next_st.fsm = H_CAPT;
			H_CAPT: begin
				next_st.rdata = link.rdata;
				next_st.fsm = H_IDLE;
				// lock-lost and recalibration may be false alarms
				if (st.addr == OFS_EV_STAT && |(link.rdata[7:0] & SUSPECT_BITS)) begin
					next_st.suspect = 1'b1;
				end
			end
		endcase

		// software port; order registers ignored while busy
		if (reg_wr_i && st.fsm == H_IDLE) begin
			unique case (reg_addr_i)
				HOF_ADDR:   next_st.addr = reg_wdata_i[7:0];
				HOF_WDATA:  next_st.wdata = reg_wdata_i;
				HOF_STATUS: begin
					next_st.refused = st.refused & ~reg_wdata_i[ST_REFUSED];
					next_st.suspect = st.suspect & ~reg_wdata_i[ST_SUSPECT];
				end
				HOF_CKOUT:  next_st.ckout_req = reg_wdata_i[0];
				default:    next_st.addr = next_st.addr;
			endcase
		end
		next_st.reg_rdata = 16'h0000;
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				HOF_ADDR:   next_st.reg_rdata = {8'h00, st.addr};
				HOF_WDATA:  next_st.reg_rdata = st.wdata;
				HOF_STATUS: next_st.reg_rdata = {12'h000, st.suspect, st.refused,
					st.irq, st.fsm != H_IDLE};
				HOF_RDATA:  next_st.reg_rdata = st.rdata;
				HOF_CKOUT:  next_st.reg_rdata = {15'h0000, st.ckout_req};
				default:    next_st.reg_rdata = 16'h0000;
			endcase
		end
		next_st.irq_s1 = ~link.interrupt_request_n;
		next_st.irq = st.irq_s1;
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			st <= '{fsm: H_IDLE, default: '0};
		end else if (ce_i) begin
			st <= next_st;
		end
	end

	assign link.addr = st.addr;
	assign link.wdata = st.wdata;
	assign link.wr = st.l_wr;
	assign link.rd = st.l_rd;
	// clock output only after its divider has been set
	assign link.clock_out_enable = st.ckout_req && st.ckdiv_set;
	assign reg_rdata_o = st.reg_rdata;
	assign irq_o = st.irq;
endmodule

/* logic/scr_link_if.sv */
/*
 * scr_link_if: register link between the host controller and the device.
 * assumes: both ends on the same clock; one access per strobe.
 */
`timescale 1ns/1ns
interface scr_link_if;
	logic [7:0]  addr;
	logic [15:0] wdata;
	logic        wr;
	logic        rd;
	logic [15:0] rdata;
	logic        interrupt_request_n;
	logic        clock_out_enable;
	modport dev (input addr, input wdata, input wr, input rd, input clock_out_enable,
		output rdata, output interrupt_request_n);
	modport host (output addr, output wdata, output wr, output rd, output clock_out_enable,
		input rdata, input interrupt_request_n);
endinterface

/* logic/scr_pkg.sv */
/*
 * scr_pkg: offsets, field positions, reset values and codes shared by
 * both ends of the synthesizer control register link.
 * assumes: nothing beyond a SystemVerilog compiler.
 */
package scr_pkg;
	// device register offsets
	localparam logic [7:0] OFS_GCR       = 8'h2E;
	localparam logic [7:0] OFS_FREQ      = 8'h2F;
	localparam logic [7:0] OFS_GEN_RST   = 8'h30;
	localparam logic [7:0] OFS_EV_EN     = 8'h31;
	localparam logic [7:0] OFS_EV_MASK   = 8'h32;
	localparam logic [7:0] OFS_LOOP      = 8'h34;
	localparam logic [7:0] OFS_SOURCE_DIVIDE_VALUE      = 8'h4D;
	localparam logic [7:0] OFS_CKDIV     = 8'h7D;
	localparam logic [7:0] OFS_SOURCE_DIVIDE_VALUE_RB   = 8'hAD;
	localparam logic [7:0] OFS_GCR_RB    = 8'hAE;
	localparam logic [7:0] OFS_FREQ_RB   = 8'hAF;
	localparam logic [7:0] OFS_EV_STAT   = 8'hB0;
	localparam logic [7:0] OFS_EV_EN_RB  = 8'hB1;
	localparam logic [7:0] OFS_EV_MSK_RB = 8'hB2;
	localparam logic [7:0] OFS_VCO_STAT  = 8'hC4;
	localparam logic [7:0] OFS_REFDIV_RB = 8'hCB;
	localparam logic [7:0] OFS_REFPWR_RB = 8'hCC;
	localparam logic [7:0] OFS_CKDIV_RB  = 8'hCD;
	// reset values
	localparam logic [15:0] RST_GCR    = 16'h0000;
	localparam logic [7:0]  RST_FREQ   = 8'h26;
	localparam logic [7:0]  RST_EV     = 8'h40;
	localparam logic [7:0]  RST_LOOP   = 8'h00;
	localparam logic [6:0]  RST_SOURCE_DIVIDE_VALUE   = 7'h08;
	localparam logic [1:0]  RST_CKDIV  = 2'h0;
	localparam logic [7:0]  RST_REFDIV = 8'h03;
	localparam logic [7:0]  RST_REFPWR = 8'h00;
	// general control fields
	localparam int GCR_LOOP_EN  = 0;
	localparam int GCR_EXT_VCO  = 1;
	localparam int GCR_EXT_POL  = 2;
	localparam int GCR_CAL      = 3;
	localparam int GCR_LOCK_DET = 5;
	localparam int GCR_OUT1     = 6;
	localparam int GCR_OUT2     = 7;
	localparam int GCR_MCLK_EN  = 10;
	localparam logic [15:0] GCR_USED = 16'h04EF;
	// clock frequency fields
	localparam int FREQ_SRC_EN = 7;
	localparam logic [6:0] FREQ_MIN = 7'h0A;
	localparam logic [6:0] FREQ_MAX = 7'h78;
	localparam logic [6:0] SOURCE_DIVIDE_VALUE_MIN = 7'h04;
	// loop control fields
	localparam int LOOP_WIDTH_SEL = 4;
	localparam int LOOP_RSVD      = 5;
	localparam logic [2:0] MODE_INTEGER = 3'h0;
	localparam logic [2:0] MODE_FRACT   = 3'h2;
	localparam logic [7:0] LOOP_USED    = 8'h17;
	// event bit positions, shared by enable, mask and status
	localparam int EV_MCLK_READY = 6;
	localparam int EV_CAL_DONE   = 5;
	localparam int EV_LOCK_LOST  = 3;
	localparam int EV_LOCK_GAIN  = 2;
	localparam int EV_RECAL      = 1;
	localparam logic [7:0] EV_USED  = 8'h6E;
	localparam logic [7:0] VCO_USED = 8'hCC;
	// host command registers
	localparam logic [2:0] HOF_ADDR   = 3'h0;
	localparam logic [2:0] HOF_WDATA  = 3'h1;
	localparam logic [2:0] HOF_GO     = 3'h2;
	localparam logic [2:0] HOF_STATUS = 3'h3;
	localparam logic [2:0] HOF_RDATA  = 3'h4;
	localparam logic [2:0] HOF_CKOUT  = 3'h5;
	localparam int GO_WRITE = 0;
	localparam int GO_READ  = 1;
	localparam int ST_BUSY    = 0;
	localparam int ST_IRQ     = 1;
	localparam int ST_REFUSED = 2;
	localparam int ST_SUSPECT = 3;
	localparam logic [7:0] SUSPECT_BITS = 8'h0A;
endpackage

/* tb/scr_link_asserts.sv */
/*
 * scr_link_asserts: checks on the link between host and device ends.
 * assumes: one clock, synchronous reset, wired to the link signals.
 */
`timescale 1ns/1ns
module scr_link_asserts (
	input logic        clk_i,
	input logic        sys_rst_i,
	input logic [7:0]  addr,
	input logic [15:0] wdata,
	input logic        wr,
	input logic        rd,
	input logic [15:0] rdata,
	input logic        interrupt_request_n,
	input logic        clock_out_enable
);
	import scr_pkg::*;
	typedef struct packed {
		logic [15:0] gcr;
		logic [7:0]  msk;
		logic [6:0]  source_divide_value;
		logic        ck;
	} scr_shadow_t;
	scr_shadow_t st;
	scr_shadow_t next_st;
	// shadow of what crossed the link; the shadow's divider flag survives a gen reset, though the host clears its own
	always_comb begin
		next_st = st;
		if (wr && addr == OFS_GCR) next_st.gcr = wdata & GCR_USED;
		if (wr && addr == OFS_EV_MASK) next_st.msk = wdata[7:0] & EV_USED;
		if (wr && addr == OFS_SOURCE_DIVIDE_VALUE) next_st.source_divide_value = wdata[6:0];
		if (wr && addr == OFS_CKDIV) next_st.ck = 1'b1;
		if (wr && addr == OFS_GEN_RST) next_st = '{RST_GCR, RST_EV, RST_SOURCE_DIVIDE_VALUE, st.ck};
		if (sys_rst_i) next_st = '{RST_GCR, RST_EV, RST_SOURCE_DIVIDE_VALUE, 1'b0};
	end
	always_ff @(posedge clk_i) begin
		st <= next_st;
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	chk_strobe_excl: assert property (!(wr && rd))
		else $error("write and read strobes together");
	chk_read_pulse: assert property (rd |=> !rd)
		else $error("read strobe longer than one cycle");
	chk_rdata_idle: assert property (!$past(rd) |-> rdata == 16'h0000)
		else $error("read data outside its cycle");
	// calibration trigger self-clears, so b3 is left out of the compare
	chk_gcr_mirror: assert property (rd && addr == OFS_GCR_RB |=>
		(rdata & 16'hFFF7) == (st.gcr & 16'hFFF7)) else $error("control readback wrong");
	chk_source_divide_value_mirror: assert property (rd && addr == OFS_SOURCE_DIVIDE_VALUE_RB |=>
		rdata == {9'h000, st.source_divide_value}) else $error("source divider readback wrong");
	chk_mask_mirror: assert property (rd && addr == OFS_EV_MSK_RB |=>
		rdata == {8'h00, st.msk}) else $error("mask readback wrong");
	chk_stat_layout: assert property (rd && addr == OFS_EV_STAT |=>
		(rdata & ~{8'h00, EV_USED}) == 16'h0000) else $error("status unused bit set");
	chk_refdiv_fixed: assert property (rd && addr == OFS_REFDIV_RB |=>
		rdata == 16'h0003) else $error("reference divider readback wrong");
	chk_irq_masked: assert property ((st.msk == 8'h00) [*3] |->
		interrupt_request_n) else $error("interrupt with all events masked");
	chk_cal_pair: assert property (wr && addr == OFS_GCR && wdata[3] |->
		wdata[0]) else $error("calibration without loop enable");
	chk_freq_legal: assert property (wr && addr == OFS_FREQ |->
		wdata[6:0] >= 7'h0A && wdata[6:0] <= 7'h78 && !st.gcr[10])
		else $error("illegal frequency write");
	chk_source_divide_value_legal: assert property (wr && addr == OFS_SOURCE_DIVIDE_VALUE |->
		wdata[6:0] >= 7'h04) else $error("illegal source divider write");
	chk_rsvd_zero: assert property (wr && addr == OFS_LOOP |-> !wdata[5])
		else $error("reserved loop bit written as one");
	chk_clkout_order: assert property (clock_out_enable |-> st.ck)
		else $error("clock output enabled before divider set");
	cov_gen_rst: cover property (wr && addr == OFS_GEN_RST);
	cov_irq: cover property ($fell(interrupt_request_n));
	cov_stat_read: cover property (rd && addr == OFS_EV_STAT);
endmodule

/* tb/synth_control_regs_tb.sv */
/*
 * synth_control_regs_tb: host and device ends joined by the link; the bench
 * drives the host register port and the device event pulses.
 * assumes: package, link interface and both ends compiled first.
 */
`timescale 1ns/1ns
module synth_control_regs_tb;
	import scr_pkg::*;
	logic        clk_i;
	logic        sys_rst_i;
	logic [2:0]  reg_addr_i;
	logic [15:0] reg_wdata_i;
	logic        reg_wr_i;
	logic        reg_rd_i;
	logic [15:0] reg_rdata_o;
	logic        irq_o;
	logic [4:0]  ev;
	logic        ce;
	logic        cal_start;
	int          n_starts = 0;
	logic [7:0]  vco_status_i;
	logic        clock_out_o, mclk_en, loop_en, vco_pwr, ext_sel, ext_pol, cal_busy, cal_vco;
	logic        src_en;
	logic [6:0]  freq, source_divide_value;
	logic [2:0]  mode;
	logic [7:0]  outs;
	logic [15:0] d;
	int          c;
	int          n_errors = 0;
	int          total_checks = 0;
	scr_link_if link ();
	scr_host scr_host_inst (.clk_i, .sys_rst_i, .ce_i(ce), .link(link.host),
		.reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .irq_o);
	scr_device scr_device_inst (.clk_i, .sys_rst_i, .ce_i(ce), .link(link.dev),
		.mclk_ready_i(ev[4]), .cal_done_i(ev[3]), .lock_lost_i(ev[2]),
		.lock_gained_i(ev[1]), .recal_needed_i(ev[0]), .vco_status_i, .clock_out_o,
		.synth_master_clock_enable_o(mclk_en), .loop_enable_o(loop_en),
		.internal_vco_power_o(vco_pwr), .external_vco_select_o(ext_sel),
		.external_vco_polarity_o(ext_pol), .cal_start_o(cal_start), .cal_with_vco_o(cal_vco),
		.cal_busy_o(cal_busy), .source_divider_enable_o(src_en), .synth_clock_freq_o(freq),
		.source_divide_value_o(source_divide_value), .integer_mode_o(mode[2]),
		.fractional_mode_o(mode[1]), .fraction_24bit_o(mode[0]), .output_enables_o(outs));
	scr_link_asserts scr_link_asserts_inst (.clk_i, .sys_rst_i, .addr(link.addr),
		.wdata(link.wdata), .wr(link.wr), .rd(link.rd), .rdata(link.rdata),
		.interrupt_request_n(link.interrupt_request_n),
		.clock_out_enable(link.clock_out_enable));
	// start pulses last one cycle, so count them rather than sample them
	always @(posedge clk_i) begin
		if (cal_start === 1'b1) n_starts <= n_starts + 1;
	end
	task automatic results();
		if (n_errors == 0 && total_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic rw(input logic [2:0] a, input logic [15:0] v);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= v;
		reg_wr_i <= 1'b1;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	endtask
	task automatic rr(input logic [2:0] a, output logic [15:0] v);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		#1 v = reg_rdata_o;
	endtask
	// busy poll is bounded so a stuck controller cannot hang the run
	task automatic go(input logic [7:0] o, input logic [15:0] v, input int op);
		logic [15:0] s;
		rw(HOF_ADDR, {8'h00, o});
		rw(HOF_WDATA, v);
		rw(HOF_GO, 16'h0001 << op);
		for (int i = 0; i < 30; i++) begin
			rr(HOF_STATUS, s);
			if (!s[ST_BUSY]) break;
		end
		chk(16'(s[ST_BUSY]), 16'h0000);
	endtask
	task automatic lw(input logic [7:0] o, input logic [15:0] v);
		go(o, v, GO_WRITE);
	endtask
	task automatic rb(input logic [7:0] o, input logic [15:0] e);
		logic [15:0] v;
		go(o, 16'h0000, GO_READ);
		rr(HOF_RDATA, v);
		chk(v, e);
	endtask
	task automatic pulse(input int i);
		@(posedge clk_i);
		ev[i] <= 1'b1;
		@(posedge clk_i);
		ev[i] <= 1'b0;
		repeat (3) @(posedge clk_i);
		#1;
	endtask
	task automatic t_defaults();
		rb(OFS_GCR_RB, 16'h0000);
		rb(OFS_FREQ_RB, 16'h0026);
		rb(OFS_SOURCE_DIVIDE_VALUE_RB, 16'h0008);
		rb(OFS_EV_EN_RB, 16'h0040);
		rb(OFS_EV_MSK_RB, 16'h0040);
		rb(OFS_CKDIV_RB, 16'h0000);
		rb(OFS_REFPWR_RB, 16'h0000);
		rb(OFS_VCO_STAT, 16'h00CC);
		rb(8'h01, 16'h0000);
	endtask
	task automatic t_controls();
		lw(OFS_GCR, 16'hFFF6);
		rb(OFS_GCR_RB, 16'h04E6);
		chk(16'({mclk_en, ext_sel, ext_pol, loop_en, cal_vco, outs}), 16'h1CE0);
		lw(OFS_GCR, 16'h0401);
		chk(16'({loop_en, vco_pwr, ext_sel}), 16'h0006);
		lw(OFS_LOOP, 16'h0032);
		chk(16'(mode), 16'h0002);
		lw(OFS_LOOP, 16'h0000);
		chk(16'(mode), 16'h0005);
	endtask
	task automatic t_refuse();
		lw(OFS_FREQ, 16'h0050);
		rr(HOF_STATUS, d);
		chk(16'(d[ST_REFUSED]), 16'h0001);
		rw(HOF_STATUS, 16'h0004);
		lw(OFS_GCR, 16'h0000);
		lw(OFS_FREQ, 16'h0009);
		lw(OFS_FREQ, 16'h0079);
		lw(OFS_SOURCE_DIVIDE_VALUE, 16'h0003);
		rb(OFS_FREQ_RB, 16'h0026);
		rb(OFS_SOURCE_DIVIDE_VALUE_RB, 16'h0008);
		lw(OFS_FREQ, 16'h00F8);
		lw(OFS_SOURCE_DIVIDE_VALUE, 16'h007F);
		rb(OFS_FREQ_RB, 16'h00F8);
		chk(16'({src_en, freq, source_divide_value}), 16'h7C7F);
	endtask
	task automatic t_events();
		pulse(4); // master clock off, so ignored
		lw(OFS_GCR, 16'h0400);
		lw(OFS_EV_EN, 16'h006E);
		lw(OFS_EV_MASK, 16'h0000);
		pulse(1);
		rb(OFS_EV_EN_RB, 16'h006A);
		chk(16'(link.interrupt_request_n), 16'h0001);
		rb(OFS_EV_STAT, 16'h0004);
		pulse(1);
		rb(OFS_EV_STAT, 16'h0000);
		lw(OFS_EV_MASK, 16'h0028);
		pulse(2);
		chk(16'({link.interrupt_request_n, irq_o}), 16'h0001);
		rb(OFS_EV_STAT, 16'h0008);
		rr(HOF_STATUS, d);
		chk(16'({d[ST_SUSPECT], link.interrupt_request_n}), 16'h0003);
		lw(OFS_GCR, 16'h0408);
		repeat (2) @(posedge clk_i);
		#1 chk(16'({cal_busy, cal_vco}), 16'h0003);
		chk(16'(n_starts), 16'h0001);
		pulse(3);
		rb(OFS_GCR_RB, 16'h0401);
		chk(16'(link.interrupt_request_n), 16'h0000);
		rb(OFS_EV_STAT, 16'h0020);
	endtask
	task automatic rise();
		logic p;
		p = clock_out_o;
		c = 0;
		while (c < 40 && !(p === 1'b0 && clock_out_o === 1'b1)) begin
			p = clock_out_o;
			@(posedge clk_i);
			#1 c++;
		end
	endtask
	task automatic t_clkout();
		lw(OFS_GCR, 16'h0400);
		for (int n = 0; n < 4; n++) begin
			lw(OFS_CKDIV, 16'(n));
			rw(HOF_CKOUT, 16'h0001);
			rb(OFS_CKDIV_RB, 16'(n));
			rise();
			rise();
			chk(16'(c), 16'(2 * n + 2));
		end
		// frozen for one toggle span, so a running divider would show a change
		@(posedge clk_i);
		ce <= 1'b0;
		repeat (2) @(posedge clk_i);
		#1 d = 16'(clock_out_o);
		repeat (4) @(posedge clk_i);
		#1 chk(16'(clock_out_o), d);
		@(posedge clk_i);
		ce <= 1'b1;
		rise();
		rise();
		chk(16'(c), 16'h0008);
		lw(OFS_GCR, 16'h0000);
		rise();
		rise();
		chk(16'(c), 16'h0028);
	endtask
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	// the whole sequence needs under a thousand cycles
	initial begin
		#200000;
		n_errors++;
		results();
	end
	initial begin
		sys_rst_i = 1'b1;
		reg_addr_i = 3'h0;
		reg_wdata_i = 16'h0000;
		reg_wr_i = 1'b0;
		reg_rd_i = 1'b0;
		ev = 5'h00;
		ce = 1'b1;
		vco_status_i = 8'hFF;
		repeat (5) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		t_defaults();
		t_controls();
		t_refuse();
		t_events();
		t_clkout();
		lw(OFS_GEN_RST, 16'h0000);
		t_defaults();
		results();
	end
endmodule
